// ### rtl/output_pll_cfg.svh
// Overview of operation
// - Seven-bit pump current code, 3.5 uA steps.
// - Eight-bit feedback ratio, valid 14 to 255.
// - Two-bit second-pole resistor select, register reset 7F.
// - Three-bit zero resistor select, reset 111.
// - Three-bit first-pole capacitor select, reset 111.
// - Post divider held reset while bit set.
// - Bypass bit shorts internal zero resistor.
// - Post divider register upper six bits reserved.
`ifndef OUTPUT_PLL_CFG_SVH
`define OUTPUT_PLL_CFG_SVH

// Register offsets on the local register port
`define CP_CURRENT_ADDR    16'h0430
`define FB_RATIO_ADDR      16'h0431
`define LOOP_FILTER_ADDR   16'h0432
`define POST_DIV_ADDR      16'h0433
`define STATUS_ADDR        16'h04F0

// Reset values
`define CP_CURRENT_RST     8'h2E
`define FB_RATIO_RST       8'h00
`define LOOP_FILTER_RST    8'h7F
`define POST_DIV_RST       8'h00

// Field positions
`define CP_CODE_MSB        6
`define RP2_MSB            7
`define RP2_LSB            6
`define RZ_MSB             5
`define RZ_LSB             3
`define CP1_MSB            2
`define CP1_LSB            0
`define PD_RST_BIT         1
`define RZ_BYP_BIT         0
`define ST_FB_VALID_BIT    0
`define ST_PD_HELD_BIT     1
`define ST_EXT_RZ_BIT      2

// Pump current step in nA and feedback ratio limits
`define CP_LSB_NA          19'h0_0DAC
`define FB_RATIO_MIN       8'h0E
`define FB_RATIO_MAX       8'hFF

`endif

// ### rtl/output_pll_pkg.sv
`default_nettype none
package output_pll_pkg;
   typedef logic [10:0] ohm_t;   // Resistance in ohms
   typedef logic [7:0]  pf_t;    // Capacitance in pF
   typedef logic [18:0] na_t;    // Current in nA

   // Complete state of the register bank
   typedef struct packed {
      logic [6:0] cp_code;       // Pump current code
      logic [7:0] fb_ratio;      // Feedback divider ratio
      logic [7:0] lf_sel;        // Loop filter selections
      logic       pd_rst;        // Post divider hold
      logic       rz_byp;        // Zero resistor bypass
      logic [7:0] rdata;         // Read data holding stage
      na_t        cp_na;         // Decoded pump current
      ohm_t       rp2_ohm;       // Decoded second-pole resistor
      ohm_t       rz_ohm;        // Effective zero resistor
      pf_t        cp1_pf;        // Decoded first-pole capacitor
      logic       fb_valid;      // Ratio within operating range
   } state_s;
endpackage
`default_nettype wire

// ### rtl/loop_filter_if.sv
`default_nettype none
interface loop_filter_if;
   import output_pll_pkg::*;
   logic [1:0] rp2_sel;   // Second-pole resistor code
   logic [2:0] rz_sel;    // Zero resistor code
   logic [2:0] cp1_sel;   // First-pole capacitor code
   ohm_t       rp2_ohm;   // Decoded values
   ohm_t       rz_ohm;
   pf_t        cp1_pf;

   // Decoder sees codes and returns values
   modport decoder (input rp2_sel, rz_sel, cp1_sel, output rp2_ohm, rz_ohm, cp1_pf);
   // Register bank drives codes and reads values
   modport bank (output rp2_sel, rz_sel, cp1_sel, input rp2_ohm, rz_ohm, cp1_pf);
endinterface
`default_nettype wire

// ### rtl/loop_filter_decode.sv
`default_nettype none
module loop_filter_decode (
   loop_filter_if.decoder lf
);
   import output_pll_pkg::*;

   // Component tables, indexed by code
   localparam ohm_t RP2_TAB [4] = '{11'd500, 11'd333, 11'd250, 11'd200};
   localparam ohm_t RZ_TAB [8]  = '{11'd1500, 11'd1250, 11'd1000, 11'd930,
                                    11'd1250, 11'd1000, 11'd750, 11'd680};
   localparam pf_t  CP1_TAB [8] = '{8'd10, 8'd30, 8'd40, 8'd70,
                                    8'd90, 8'd110, 8'd130, 8'd150};

   // Pure table lookups; every code is legal so no fallback is needed
   always_comb begin
      lf.rp2_ohm = RP2_TAB[lf.rp2_sel];
      lf.rz_ohm  = RZ_TAB[lf.rz_sel];
      lf.cp1_pf  = CP1_TAB[lf.cp1_sel];
   end
endmodule // loop_filter_decode
`default_nettype wire

// ### rtl/output_pll_config_regs.sv
`include "output_pll_cfg.svh"
`default_nettype none
module output_pll_config_regs (
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            ce,
   // Register port
   input  wire logic [15:0]     reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output var  logic [7:0]      reg_rdata,
   // Charge pump
   output var  logic [6:0]      cp_current_code,
   output var  output_pll_pkg::na_t cp_current_na,
   // Feedback divider
   output var  logic [7:0]      loop_feedback_divider,
   output var  logic            feedback_ratio_valid,
   // Loop filter selections
   output var  logic [1:0]      second_pole_resistor_sel,
   output var  logic [2:0]      zero_resistor_sel,
   output var  logic [2:0]      first_pole_capacitor_sel,
   output var  output_pll_pkg::ohm_t second_pole_resistor_ohm,
   output var  output_pll_pkg::ohm_t zero_resistor_ohm,
   output var  output_pll_pkg::pf_t  first_pole_capacitor_pf,
   // Post divider and bypass controls
   output var  logic            output_post_divider_rst,
   output var  logic            zero_resistor_bypass,
   output var  logic            ext_zero_resistor_req
);
   import output_pll_pkg::*;

   // Reset image of the whole bank
   localparam state_s RESET_STATE = '{
      cp_code:  7'(`CP_CURRENT_RST),
      fb_ratio: `FB_RATIO_RST,
      lf_sel:   `LOOP_FILTER_RST,
      pd_rst:   1'b0,
      rz_byp:   1'b0,
      rdata:    8'h00,
      cp_na:    '0,
      rp2_ohm:  11'd333,
      rz_ohm:   11'd680,
      cp1_pf:   8'd150,
      fb_valid: 1'b0
   };

   state_s        st_q;        // Registered state
   state_s        st_d;        // Next state

   // Decoded strobes per register
   logic          hit_cp;      // Pump current register addressed
   logic          hit_fb;      // Feedback ratio register addressed
   logic          hit_lf;      // Loop filter register addressed
   logic          hit_pd;      // Post divider register addressed
   logic          hit_st;      // Status register addressed
   logic [7:0]    status_word; // Live status bits
   logic [7:0]    read_word;   // Word chosen for a read
   logic [7:0]    lf_next;     // Loop filter byte after this edge

   // Carrier to the component decoder
   loop_filter_if lf_bus ();

   // Next loop filter byte, worked out apart from the state so that the
   // decoder does not sit in a loop through the next-state struct
   always_comb begin
      lf_next = st_q.lf_sel;
      if (reg_wr && hit_lf) begin
         lf_next = reg_wdata;
      end
   end

   // Codes go to the decoder from the next value so that the decoded
   // values land in the same edge as the selection fields themselves
   assign lf_bus.rp2_sel = lf_next[`RP2_MSB:`RP2_LSB];
   assign lf_bus.rz_sel  = lf_next[`RZ_MSB:`RZ_LSB];
   assign lf_bus.cp1_sel = lf_next[`CP1_MSB:`CP1_LSB];

   // Table lookup for resistor and capacitor values
   loop_filter_decode u_decode (
      .lf (lf_bus)
   );

   // Address decode; the port is byte wide, so offsets are used as printed
   always_comb begin
      hit_cp = (reg_addr == `CP_CURRENT_ADDR);
      hit_fb = (reg_addr == `FB_RATIO_ADDR);
      hit_lf = (reg_addr == `LOOP_FILTER_ADDR);
      hit_pd = (reg_addr == `POST_DIV_ADDR);
      hit_st = (reg_addr == `STATUS_ADDR);
   end

   // Status view of the bank's own state
   always_comb begin
      status_word = 8'h00;
      status_word[`ST_FB_VALID_BIT] = st_q.fb_valid;
      status_word[`ST_PD_HELD_BIT]  = st_q.pd_rst;
      status_word[`ST_EXT_RZ_BIT]   = st_q.rz_byp;
   end

   // Read mux; reserved bits and unmapped offsets return zero
   always_comb begin
      read_word = 8'h00;
      if (hit_cp) begin
         read_word = {1'b0, st_q.cp_code};
      end else if (hit_fb) begin
         read_word = st_q.fb_ratio;
      end else if (hit_lf) begin
         read_word = st_q.lf_sel;
      end else if (hit_pd) begin
         // Upper six bits always read as zero
         read_word = {6'h00, st_q.pd_rst, st_q.rz_byp};
      end else if (hit_st) begin
         read_word = status_word;
      end
   end

   // Next-state logic for the whole bank
   always_comb begin
      st_d = st_q;
      // Read data lives for exactly one cycle after the strobe
      st_d.rdata = 8'h00;
      if (reg_rd) begin
         st_d.rdata = read_word;
      end
      if (reg_wr) begin
         if (hit_cp) begin
            // Bit 7 is reserved and the write to it is dropped
            st_d.cp_code = reg_wdata[`CP_CODE_MSB:0];
         end
         if (hit_fb) begin
            // Out-of-range ratios are stored anyway; the flag tells
            // software the loop will not run at that setting
            st_d.fb_ratio = reg_wdata;
         end
         if (hit_lf) begin
            // All three selections share one byte
            st_d.lf_sel = reg_wdata;
         end
         if (hit_pd) begin
            // Only the two low bits are kept
            st_d.pd_rst = reg_wdata[`PD_RST_BIT];
            st_d.rz_byp = reg_wdata[`RZ_BYP_BIT];
         end
         // Writes to the status view and unmapped offsets are ignored
      end
      // Derived values follow their fields in the same edge
      // Pump current in nA: each code step is one 3.5 uA unit
      st_d.cp_na    = 19'(st_d.cp_code) * `CP_LSB_NA;
      // Ratio is usable only from 14 through 255
      st_d.fb_valid = (st_d.fb_ratio >= `FB_RATIO_MIN) &&
                      (st_d.fb_ratio <= `FB_RATIO_MAX);
      st_d.rp2_ohm  = lf_bus.rp2_ohm;
      // A bypassed zero resistor is zero ohms; the decoded code is kept
      // in the register so clearing the bypass restores it at once
      if (st_d.rz_byp) begin
         st_d.rz_ohm = '0;
      end else begin
         st_d.rz_ohm = lf_bus.rz_ohm;
      end
      st_d.cp1_pf = lf_bus.cp1_pf;
   end

   // State register; clock enable low freezes everything, including
   // the read stage, so a stalled read keeps its data
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= RESET_STATE;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   always_comb begin
      reg_rdata                = st_q.rdata;
      cp_current_code          = st_q.cp_code;
      cp_current_na            = st_q.cp_na;
      loop_feedback_divider    = st_q.fb_ratio;
      feedback_ratio_valid     = st_q.fb_valid;
      second_pole_resistor_sel = st_q.lf_sel[`RP2_MSB:`RP2_LSB];
      zero_resistor_sel        = st_q.lf_sel[`RZ_MSB:`RZ_LSB];
      first_pole_capacitor_sel = st_q.lf_sel[`CP1_MSB:`CP1_LSB];
      second_pole_resistor_ohm = st_q.rp2_ohm;
      zero_resistor_ohm        = st_q.rz_ohm;
      first_pole_capacitor_pf  = st_q.cp1_pf;
      // Post divider is held while the bit is one, runs when zero
      output_post_divider_rst  = st_q.pd_rst;
      zero_resistor_bypass     = st_q.rz_byp;
      // Bypass needs a resistor on the loop filter pin
      ext_zero_resistor_req    = st_q.rz_byp;
   end
endmodule // output_pll_config_regs
`default_nettype wire

// ### bench/pll_cfg_asserts.sv
`default_nettype none
module pll_cfg_asserts (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic                 ce,
   input wire logic [15:0]          reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   input wire logic [6:0]           cp_current_code,
   input wire output_pll_pkg::na_t  cp_current_na,
   input wire logic [7:0]           loop_feedback_divider,
   input wire logic                 feedback_ratio_valid,
   input wire logic [1:0]           second_pole_resistor_sel,
   input wire output_pll_pkg::ohm_t second_pole_resistor_ohm,
   input wire output_pll_pkg::ohm_t zero_resistor_ohm,
   input wire logic                 output_post_divider_rst,
   input wire logic                 zero_resistor_bypass,
   input wire logic                 ext_zero_resistor_req
);
   import output_pll_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Accepted strobes; a strobe with ce low is lost
   sequence s_wr(a); ce && reg_wr && reg_addr == a; endsequence
   sequence s_rd(a); ce && reg_rd && reg_addr == a; endsequence
   property p_cp; s_wr(16'h0430) |=> cp_current_code == $past(reg_wdata[6:0]); endproperty
   a_cp: assert property (p_cp) else $error("pump code not written");
   // Skips the edge after reset, where the current is still being recomputed
   property p_na; ce && !$past(rst) |=> cp_current_na == cp_current_code * 19'h0_0DAC; endproperty
   a_na: assert property (p_na) else $error("pump current wrong");
   property p_fb; feedback_ratio_valid == (loop_feedback_divider >= 8'h0E); endproperty
   a_fb: assert property (p_fb) else $error("ratio flag wrong");
   property p_rp2;
      second_pole_resistor_ohm == (second_pole_resistor_sel == 2'h0 ? 11'h1F4 :
         second_pole_resistor_sel == 2'h1 ? 11'h14D :
         second_pole_resistor_sel == 2'h2 ? 11'h0FA : 11'h0C8);
   endproperty
   a_rp2: assert property (p_rp2) else $error("pole resistor wrong");
   property p_byp; zero_resistor_bypass |-> zero_resistor_ohm == 11'h000 && ext_zero_resistor_req;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass not applied");
   property p_pd;
      s_wr(16'h0433) |=> output_post_divider_rst == $past(reg_wdata[1])
         && zero_resistor_bypass == $past(reg_wdata[0]);
   endproperty
   a_pd: assert property (p_pd) else $error("divider hold not written");
   property p_rsv; s_rd(16'h0433) |=> reg_rdata[7:2] == 6'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits read set");
   property p_rd; s_rd(16'h0431) |=> reg_rdata == loop_feedback_divider; endproperty
   a_rd: assert property (p_rd) else $error("ratio readback wrong");
   // Read data stand one cycle only
   property p_idle; ce && !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data lingers");
endmodule // pll_cfg_asserts
bind output_pll_config_regs pll_cfg_asserts i_chk (.ref_clk, .rst, .ce, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .cp_current_code, .cp_current_na, .loop_feedback_divider,
   .feedback_ratio_valid, .second_pole_resistor_sel, .second_pole_resistor_ohm,
   .zero_resistor_ohm, .output_post_divider_rst, .zero_resistor_bypass, .ext_zero_resistor_req);
`default_nettype wire

// ### bench/post_divider_model.sv
`default_nettype none
module post_divider_model (
   input wire logic        ref_clk,
   input wire logic        hold,
   output var logic [15:0] ticks
);
   timeunit 1ns;
   timeprecision 1ns;
   // Divider advances each edge unless held in reset
   initial ticks = 16'h0000;
   always @(posedge ref_clk) if (!hold) ticks <= ticks + 16'h0001;
endmodule // post_divider_model
`default_nettype wire

// ### bench/test_output_pll_config_regs.sv
`default_nettype none
module test_output_pll_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import output_pll_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000, ticks, t0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, loop_feedback_divider;
   logic [6:0] cp_current_code;
   logic [1:0] second_pole_resistor_sel;
   logic [2:0] zero_resistor_sel, first_pole_capacitor_sel;
   logic feedback_ratio_valid, output_post_divider_rst, zero_resistor_bypass, ext_zero_resistor_req;
   na_t cp_current_na;
   ohm_t second_pole_resistor_ohm, zero_resistor_ohm;
   pf_t first_pole_capacitor_pf;
   int fails = 0, total_checks = 0, cycles = 0;
   // Expected decodes per selection code
   logic [10:0] rp2_tab [4] = '{11'h1F4, 11'h14D, 11'h0FA, 11'h0C8};
   logic [10:0] rz_tab [8] = '{11'h5DC, 11'h4E2, 11'h3E8, 11'h3A2, 11'h4E2, 11'h3E8, 11'h2EE, 11'h2A8};
   logic [7:0] pf_tab [8] = '{8'h0A, 8'h1E, 8'h28, 8'h46, 8'h5A, 8'h6E, 8'h82, 8'h96};
   output_pll_config_regs i_dut (.ref_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cp_current_code, .cp_current_na, .loop_feedback_divider, .feedback_ratio_valid,
      .second_pole_resistor_sel, .zero_resistor_sel, .first_pole_capacitor_sel,
      .second_pole_resistor_ohm, .zero_resistor_ohm, .first_pole_capacitor_pf,
      .output_post_divider_rst, .zero_resistor_bypass, .ext_zero_resistor_req);
   post_divider_model i_div (.ref_clk, .hold(output_post_divider_rst), .ticks);
   initial forever #20 ref_clk = ~ref_clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle strobes; outputs are looked at once the taking edge has landed
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic t_reset;
      rd(16'h0430, 8'h2E);
      rd(16'h0431, 8'h00);
      rd(16'h0432, 8'h7F);
      rd(16'h0433, 8'h00);
      check(cp_current_na, 19'h2_74E8);
      check(zero_resistor_ohm, 11'h2A8);
      check(first_pole_capacitor_pf, 8'h96);
      $display("test reset done");
   endtask
   task automatic t_cp;
      wr(16'h0430, 8'hFF);
      check(cp_current_na, 19'h6_C854);
      check(cp_current_code, 7'h7F);
      rd(16'h0430, 8'h7F);
      $display("test pump done");
   endtask
   task automatic t_fb;
      logic [7:0] r [3] = '{8'h0D, 8'h0E, 8'hFF};
      for (int i = 0; i < 3; i++) begin
         wr(16'h0431, r[i]);
         check(feedback_ratio_valid, r[i] >= 8'h0E);
         check(loop_feedback_divider, r[i]);
         rd(16'h0431, r[i]);
      end
      $display("test ratio done");
   endtask
   task automatic t_lf;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = {i[1:0], i[2:0], i[2:0]};
         wr(16'h0432, v);
         check(second_pole_resistor_ohm, rp2_tab[i[1:0]]);
         check(zero_resistor_ohm, rz_tab[i]);
         check(first_pole_capacitor_pf, pf_tab[i]);
         check({second_pole_resistor_sel, zero_resistor_sel, first_pole_capacitor_sel}, v);
         rd(16'h0432, v);
      end
      $display("test filter done");
   endtask
   task automatic t_pd;
      wr(16'h0433, 8'hFF);
      rd(16'h0433, 8'h03);
      check({zero_resistor_ohm, ext_zero_resistor_req}, 12'h001);
      t0 = ticks;
      repeat (5) @(posedge ref_clk);
      #1;
      check(ticks - t0, 16'h0000);
      wr(16'h0433, 8'h00);
      t0 = ticks;
      repeat (5) @(posedge ref_clk);
      #1;
      check(ticks - t0, 16'h0005);
      check(zero_resistor_ohm, 11'h2A8);
      $display("test divider done");
   endtask
   // Unmapped and read-only offsets ignore writes
   task automatic t_unmapped;
      wr(16'h0440, 8'hFF);
      wr(16'h04F0, 8'hFF);
      rd(16'h0440, 8'h00);
      rd(16'h04F0, 8'h01);
      $display("test unmapped done");
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_cp();
      t_fb();
      t_lf();
      t_pd();
      t_unmapped();
      report_and_stop();
   end
endmodule // test_output_pll_config_regs
`default_nettype wire
